/* File: verilog/spms_port.sv */
// serial peripheral port, master or slave, behind an apb register slave
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - slave mode: select pin is input only; low activates port and output driver.
// - select high in slave mode clears the edge counter after the two-stage synchroniser; shift register keeps its value.
// - master with select as output: plain output, no effect on transfers.
// - master with select input low: drop to slave, set complete flag.
// - interrupt when complete flag, irq enable bit and global enable all set.
// - no serial operation unless the port enable bit is one.
// - order bit one shifts lsb first, zero msb first.
// - master bit one selects master, zero selects slave.
// - idle level bit sets serial clock idle level and leading edge.
// - phase zero samples on leading, sets up on trailing; one the reverse.
// - master clock divisors 4,16,64,128, doubled 2,8,32,64; slave ignores them.
// - double rate bit doubles master clock, shortest period two cycles.
// - complete flag set at byte end; cleared by ack or status read then data.
// - collision flag set on data write during transfer; cleared by status read then data, not by ack.
// - unused status bits 5 to 1 read as zero.
// - data write starts a transfer in master mode; data read returns receive buffer.
// - data driven and latched on opposite edges; modes 0 to 3.
// - master write runs eight bits then stops clock; select never automatic.
// - transmit single buffered, receive double buffered, unread byte overwritten.
// - deselected slave keeps output off, ignores clocks, data still writable.
module spms_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spms_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  output logic irq,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_n,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_n,
  input wire logic sel_n_i,
  output logic sel_n_o,
  output logic sel_n_oe_n
);
  import spms_pkg::*;

  function automatic logic tx_bit(input logic [7:0] v, input logic lsb_first);
    tx_bit = lsb_first ? v[0] : v[7];
  endfunction : tx_bit

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
    shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  function automatic logic [HALF_W-1:0] half_period(input logic [1:0] rate, input logic dbl);
    int d;
    d = DIV_0;
    unique case (rate)
      2'b00: d = DIV_0;
      2'b01: d = DIV_1;
      2'b10: d = DIV_2;
      2'b11: d = DIV_3;
    endcase
    if (dbl) begin
      d = d / 2;
    end
    half_period = HALF_W'(d / 2);
  endfunction : half_period

  logic [7:0] control_q;
  logic double_q;
  logic [4:0] pin_dir_q;
  logic complete_q;
  logic collision_q;
  logic arm_complete_q;
  logic arm_collision_q;
  logic [7:0] rx_buf_q;
  logic [7:0] sr_q;
  logic out_q;
  logic sck_q;
  logic [4:0] edge_cnt_q;
  logic done_q;
  logic [HALF_W-1:0] div_q;
  spms_state_type state_q;
  logic sck_s1, sck_s2, sck_s3;
  logic mosi_s1, mosi_s2;
  logic miso_s1, miso_s2;
  logic sel_s1, sel_s2;

  logic port_en, is_master, lsb_first, clock_sample_phase, clock_idle_level;
  logic slave_active, fault, tick, edge_ev, sample_now, din, busy;
  logic acc, wr_acc, rd_acc, data_wr, data_acc, status_rd, mapped;
  logic clr_flags;

  assign port_en = control_q[CB_PORT_EN];
  assign is_master = control_q[CB_MASTER];
  assign lsb_first = control_q[CB_ORDER];
  assign clock_sample_phase = control_q[CB_PHASE];
  assign clock_idle_level = control_q[CB_IDLE];

  // apb access phase completes on the edge where pready is high
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign mapped = is_reg(paddr, OFF_CONTROL) || is_reg(paddr, OFF_STATUS) ||
                  is_reg(paddr, OFF_DATA) || is_reg(paddr, OFF_PIN_DIR);
  assign data_acc = acc && is_reg(paddr, OFF_DATA);
  assign data_wr = wr_acc && is_reg(paddr, OFF_DATA);
  assign status_rd = rd_acc && is_reg(paddr, OFF_STATUS);

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
    end else begin
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      mosi_s1 <= mosi_i;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
      sel_s1 <= sel_n_i;
      sel_s2 <= sel_s1;
    end
  end

  assign slave_active = port_en && !is_master && !sel_s2;
  assign fault = port_en && is_master && !pin_dir_q[PD_SEL] && !sel_s2;
  assign tick = (state_q == ST_SHIFT) && (div_q == half_period(control_q[CB_RATE_HI:CB_RATE_LO], double_q) - 1'b1);
  assign edge_ev = is_master ? tick : (slave_active && (sck_s2 ^ sck_s3));
  assign sample_now = (edge_cnt_q[0] == clock_sample_phase);
  assign din = is_master ? miso_s2 : mosi_s2;
  assign busy = (state_q == ST_SHIFT) || (slave_active && edge_cnt_q != 5'h00);

  // master clock divider, one enable pulse per half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (state_q != ST_SHIFT || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  // shift engine shared by master and slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= DATA_RESET;
      out_q <= 1'b0;
      sck_q <= 1'b0;
      edge_cnt_q <= 5'h00;
      done_q <= 1'b0;
      state_q <= ST_IDLE;
    end else begin
      done_q <= 1'b0;
      if (!port_en || fault) begin
        state_q <= ST_IDLE;
        edge_cnt_q <= 5'h00;
        sck_q <= clock_idle_level;
      end else if (data_wr && !busy) begin
        sr_q <= pwdata[7:0];
        out_q <= tx_bit(pwdata[7:0], lsb_first);
        edge_cnt_q <= 5'h00;
        sck_q <= clock_idle_level;
        if (is_master) begin
          state_q <= ST_SHIFT;
        end
      end else if (!is_master && !slave_active) begin
        edge_cnt_q <= 5'h00;
      end else if (edge_ev) begin
        if (sample_now) begin
          sr_q <= shift_in(sr_q, din, lsb_first);
        end else begin
          out_q <= tx_bit(sr_q, lsb_first);
        end
        if (is_master) begin
          sck_q <= ~sck_q;
        end
        if (edge_cnt_q == EDGE_LAST) begin
          edge_cnt_q <= 5'h00;
          done_q <= 1'b1;
          state_q <= ST_IDLE;
        end else begin
          edge_cnt_q <= edge_cnt_q + 5'h01;
        end
      end else if (state_q == ST_IDLE) begin
        sck_q <= clock_idle_level;
      end
    end
  end

  // receive buffer behind the shift register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_q <= DATA_RESET;
    end else if (done_q) begin
      rx_buf_q <= sr_q;
    end
  end

  // control register; a mode fault overrides the master bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_q <= CONTROL_RESET;
    end else begin
      if (wr_acc && is_reg(paddr, OFF_CONTROL)) begin
        control_q <= pwdata[7:0];
      end
      if (fault) begin
        control_q[CB_MASTER] <= 1'b0;
      end
    end
  end

  // double rate bit, the only writable status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_q <= 1'b0;
    end else if (wr_acc && is_reg(paddr, OFF_STATUS)) begin
      double_q <= pwdata[SB_DOUBLE];
    end
  end

  // pin direction register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_dir_q <= PIN_DIR_RESET;
    end else if (wr_acc && is_reg(paddr, OFF_PIN_DIR)) begin
      pin_dir_q <= pwdata[4:0];
    end
  end

  // status flags: a set in the clearing cycle wins
  assign clr_flags = data_acc && (arm_complete_q || arm_collision_q);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      complete_q <= 1'b0;
    end else if (done_q || fault) begin
      complete_q <= 1'b1;
    end else if (irq_ack || (data_acc && arm_complete_q)) begin
      complete_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      collision_q <= 1'b0;
    end else if (data_wr && busy) begin
      collision_q <= 1'b1;
    end else if (data_acc && arm_collision_q) begin
      collision_q <= 1'b0;
    end
  end

  // clear arming: a status read with a flag set, used up by the next data access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_complete_q <= 1'b0;
      arm_collision_q <= 1'b0;
    end else begin
      if (status_rd) begin
        arm_complete_q <= complete_q || collision_q;
        arm_collision_q <= collision_q;
      end else if (clr_flags) begin
        arm_complete_q <= 1'b0;
        arm_collision_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= complete_q && control_q[CB_IRQ_EN] && global_irq_enable;
    end
  end

  // apb slave: one-cycle access phase, read data captured at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (is_reg(paddr, OFF_CONTROL)) begin
          prdata <= {24'h00_0000, control_q};
        end else if (is_reg(paddr, OFF_STATUS)) begin
          prdata <= {24'h00_0000, complete_q, collision_q, 5'h00, double_q};
        end else if (is_reg(paddr, OFF_DATA)) begin
          prdata <= {24'h00_0000, rx_buf_q};
        end else if (is_reg(paddr, OFF_PIN_DIR)) begin
          prdata <= {27'h000_0000, pin_dir_q};
        end
      end
    end
  end

  // serial clock pin, enable active low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_o <= 1'b0;
      sck_oe_n <= 1'b1;
    end else begin
      sck_o <= sck_q;
      sck_oe_n <= !(port_en && is_master && pin_dir_q[PD_SCK] && !fault);
    end
  end

  // master data out pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mosi_o <= 1'b0;
      mosi_oe_n <= 1'b1;
    end else begin
      mosi_o <= out_q;
      mosi_oe_n <= !(port_en && is_master && pin_dir_q[PD_MOSI] && !fault);
    end
  end

  // slave data out comes straight from the shift flop: an extra pin stage
  // would push the setup edge past the far master's next sample edge
  assign miso_o = out_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miso_oe_n <= 1'b1;
    end else begin
      miso_oe_n <= !(slave_active && pin_dir_q[PD_MISO]);
    end
  end

  // select pin as general output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_n_o <= 1'b1;
      sel_n_oe_n <= 1'b1;
    end else begin
      sel_n_o <= pin_dir_q[PD_SEL_LEVEL];
      sel_n_oe_n <= !(pin_dir_q[PD_SEL] && !(port_en && !is_master));
    end
  end
endmodule : spms_port

`default_nettype wire

/* File: verilog/spms_pkg.sv */
// constants for the serial peripheral port: register map, bit fields, timing
package spms_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PIN_DIR = 8'h0c;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [4:0] PIN_DIR_RESET = 5'h00;
  // control bit positions
  localparam int CB_IRQ_EN = 7;
  localparam int CB_PORT_EN = 6;
  localparam int CB_ORDER = 5;
  localparam int CB_MASTER = 4;
  localparam int CB_IDLE = 3;
  localparam int CB_PHASE = 2;
  localparam int CB_RATE_HI = 1;
  localparam int CB_RATE_LO = 0;
  // status bit positions
  localparam int SB_COMPLETE = 7;
  localparam int SB_COLLISION = 6;
  localparam int SB_DOUBLE = 0;
  // pin direction bit positions (1 = output); bit 4 is the select output level
  localparam int PD_MOSI = 0;
  localparam int PD_MISO = 1;
  localparam int PD_SCK = 2;
  localparam int PD_SEL = 3;
  localparam int PD_SEL_LEVEL = 4;
  // serial clock divisors without doubling, per rate code
  localparam int DIV_0 = 4;
  localparam int DIV_1 = 16;
  localparam int DIV_2 = 64;
  localparam int DIV_3 = 128;
  localparam int HALF_W = 7;
  localparam logic [4:0] EDGE_LAST = 5'h0f;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } spms_state_type;
endpackage : spms_pkg

/* File: bench/spms_port_asserts.sv */
// concurrent checks on the port's bus answers and pin behaviour
`timescale 1ns/1ns
`default_nettype none
module spms_port_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic irq_ack,
  input wire logic irq,
  input wire logic sck_o,
  input wire logic sck_oe_n,
  input wire logic mosi_oe_n,
  input wire logic miso_oe_n,
  input wire logic sel_n_i,
  input wire logic sel_n_oe_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_s;
    psel && penable && pready;
  endsequence
  sequence ctrl_wr_s;
    acc_s ##0 pwrite && paddr == 8'h00;
  endsequence
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h0c |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  status_zero_a: assert property (acc_s ##0 !pwrite && paddr == 8'h04 |-> prdata[31:1] == 31'h0 ||
    prdata[31:8] == 24'h0 && prdata[5:1] == 5'h00) else $error("reserved status bits set");
  irq_gate_a: assert property ($fell(global_irq_enable) |=> !irq) else $error("irq without enable");
  ack_clear_a: assert property (irq_ack |-> ##2 !irq) else $error("irq kept after ack");
  idle_level_a: assert property (ctrl_wr_s ##0 pwdata[6] && pwdata[4] |-> ##3 sck_o == $past(pwdata[3], 3))
    else $error("wrong clock idle level");
  port_off_a: assert property (ctrl_wr_s ##0 !pwdata[6] |-> ##2 sck_oe_n && mosi_oe_n && miso_oe_n)
    else $error("pins driven while disabled");
  fault_release_a: assert property ($fell(sel_n_i) && sel_n_oe_n && !sck_oe_n |-> ##[1:6] sck_oe_n && mosi_oe_n)
    else $error("no drop to slave");
  deselect_off_a: assert property ($rose(sel_n_i) && sck_oe_n |-> ##[1:6] miso_oe_n)
    else $error("miso driven when deselected");
endmodule : spms_port_asserts
bind spms_port spms_port_asserts chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .global_irq_enable, .irq_ack, .irq, .sck_o, .sck_oe_n, .mosi_oe_n, .miso_oe_n, .sel_n_i,
  .sel_n_oe_n);
`default_nettype wire

/* File: bench/spms_slave_model.sv */
// behavioural spi slave across the link from the port in master mode
`timescale 1ns/1ns
`default_nettype none
module spms_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic clock_idle_level,
  input wire logic clock_sample_phase,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte
);
  int n = 0;
  initial miso = 1'b0;
  initial rx_byte = 8'h00;
  always @(negedge sel_n) begin
    n = 0;
    miso = tx_byte[7];
  end
  // released line shows the inverse of its last level
  always @(posedge sel_n) miso = ~miso;
  always @(sck) begin
    if (!sel_n && n < 8 && sck == ~(clock_idle_level ^ clock_sample_phase)) begin
      rx_byte = {rx_byte[6:0], mosi};
      n = n + 1;
    end else if (!sel_n && n < 8) begin
      miso = tx_byte[7 - n];
    end
  end
endmodule : spms_slave_model
`default_nettype wire

/* File: bench/spms_port_tb.sv */
// testbench: register access, master and slave transfers of the serial port
`timescale 1ns/1ns
`default_nettype none
module spms_port_tb;
  import spms_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ge = 1, ack = 0, ev;
  logic tb_sck = 0, tb_mosi = 0, tb_sel = 1, pol = 0, pha = 0, pready, pslverr, irq, smiso;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, sel_n_o, sel_n_oe_n;
  logic [7:0] paddr = 8'h00, stx = 8'h00, srx, mo;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  int error_cnt = 0, checked = 0, cyc = 0;
  wire sck_w = sck_oe_n ? tb_sck : sck_o;
  wire sel_w = sel_n_oe_n ? tb_sel : sel_n_o;
  wire ssel = sel_n_oe_n | sel_n_o;
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  spms_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .global_irq_enable(ge), .irq_ack(ack), .irq, .sck_i(sck_w), .sck_o, .sck_oe_n, .mosi_i(tb_mosi), .mosi_o,
    .mosi_oe_n, .miso_i(smiso), .miso_o, .miso_oe_n, .sel_n_i(sel_w), .sel_n_o, .sel_n_oe_n);
  spms_slave_model far (.sck(sck_w), .mosi(mosi_o), .sel_n(ssel), .clock_idle_level(pol), .clock_sample_phase(pha), .tx_byte(stx),
    .miso(smiso), .rx_byte(srx));
  task automatic conclude;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("MISMATCH %0t %s %h %h", $time, m, g, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
    if (k == 20) begin
      chk(32'h0, 32'h1, "ready");
      conclude;
    end
    rv = prdata;
    ev = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic pollf;
    int k;
    for (k = 0; k < 600 && rv[7] !== 1'b1; k++) apb(0, OFF_STATUS, 8'h00);
    if (k == 600) begin
      chk(32'h0, 32'h1, "flag");
      conclude;
    end
  endtask : pollf
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7 - i];
  endfunction : rev
  task automatic sbits(input logic [7:0] b, input int n);
    repeat (4) @(posedge pclk);
    chk(miso_oe_n, 0, "miso oe");
    for (int i = 0; i < n; i++) begin
      tb_mosi <= b[7 - i];
      repeat (4) @(posedge pclk);
      tb_sck <= 1;
      mo = {mo[6:0], miso_o};
      repeat (4) @(posedge pclk);
      tb_sck <= 0;
    end
    repeat (4) @(posedge pclk);
  endtask : sbits
  task automatic t_regs;
    apb(0, OFF_CONTROL, 8'h00);
    chk(rv, 32'h0, "ctrl rst");
    apb(1, OFF_CONTROL, 8'h2f);
    apb(0, OFF_CONTROL, 8'h00);
    chk(rv, 32'h2f, "ctrl rw");
    apb(1, OFF_STATUS, 8'hff);
    apb(0, OFF_STATUS, 8'h00);
    chk(rv, 32'h01, "stat rw");
    apb(1, 8'h10, 8'hff);
    chk(ev, 1, "unmapped");
    $display("regs done");
  endtask : t_regs
  task automatic t_master;
    int h, t;
    logic [7:0] c, s, d;
    int dv[4] = '{DIV_0, DIV_1, DIV_2, DIV_3};
    for (int m = 0; m < 5; m++) begin
      c = (m == 4) ? 8'h71 : {m < 2, 3'b101, m[1:0], m[1:0] | {1'b0, m == 0}};
      s = {7'h0, m == 4};
      d = 8'h3a + m[7:0];
      stx = 8'hc5 ^ d;
      ge <= (m != 1);
      pol = c[3];
      pha = c[2];
      apb(1, OFF_STATUS, s);
      apb(1, OFF_CONTROL, c);
      apb(1, OFF_PIN_DIR, 8'h0d);
      chk(sck_o, c[3], "idle");
      apb(1, OFF_DATA, d);
      t = cyc;
      pollf;
      h = dv[c[1:0]] / (s[0] ? 4 : 2);
      chk(cyc - t >= 16 * h && cyc - t <= 16 * h + 12, 1, "rate");
      chk(irq, c[7] & ge, "irq");
      chk(rv, {24'h0, 8'h80 | s}, "stat");
      chk(srx, c[5] ? rev(d) : d, "sent");
      if (m == 0) begin
        ack <= 1;
        @(posedge pclk);
        ack <= 0;
      end
      apb(0, OFF_DATA, 8'h00);
      chk(rv, c[5] ? rev(stx) : stx, "rcvd");
      apb(0, OFF_STATUS, 8'h00);
      chk(rv, s, "clear");
      apb(1, OFF_PIN_DIR, 8'h1d);
    end
    $display("master done");
  endtask : t_master
  task automatic t_collide;
    pol = 0;
    pha = 0;
    apb(1, OFF_STATUS, 8'h00);
    apb(1, OFF_CONTROL, 8'h50);
    apb(1, OFF_PIN_DIR, 8'h0d);
    apb(1, OFF_DATA, 8'h3c);
    apb(1, OFF_DATA, 8'hc3);
    pollf;
    chk(rv, 32'hc0, "coll");
    chk(srx, 8'h3c, "kept");
    apb(0, OFF_DATA, 8'h00);
    apb(0, OFF_STATUS, 8'h00);
    chk(rv, 32'h0, "coll clr");
    apb(1, OFF_PIN_DIR, 8'h1d);
    $display("collision done");
  endtask : t_collide
  task automatic t_fault;
    int k;
    apb(1, OFF_PIN_DIR, 8'h05);
    tb_sel <= 0;
    for (k = 0; k < 20 && sck_oe_n !== 1'b1; k++) @(posedge pclk);
    chk(sck_oe_n & mosi_oe_n, 1, "release");
    apb(0, OFF_CONTROL, 8'h00);
    chk(rv, 32'h40, "master_select clr");
    apb(0, OFF_STATUS, 8'h00);
    chk(rv, 32'h80, "fault flag");
    apb(0, OFF_DATA, 8'h00);
    tb_sel <= 1;
    apb(1, OFF_CONTROL, 8'h50);
    apb(0, OFF_CONTROL, 8'h00);
    chk(rv, 32'h50, "master_select back");
    $display("fault done");
  endtask : t_fault
  task automatic t_slave;
    apb(1, OFF_PIN_DIR, 8'h02);
    apb(1, OFF_CONTROL, 8'h40);
    apb(1, OFF_DATA, 8'h96);
    tb_sel <= 0;
    sbits(8'h5a, 8);
    tb_sel <= 1;
    pollf;
    apb(0, OFF_DATA, 8'h00);
    chk(rv, 32'h5a, "slv rx");
    chk(mo, 8'h96, "slv tx");
    tb_sel <= 0;
    sbits(8'hff, 3);
    tb_sel <= 1;
    repeat (4) @(posedge pclk);
    tb_sel <= 0;
    sbits(8'h81, 8);
    tb_sel <= 1;
    pollf;
    apb(0, OFF_DATA, 8'h00);
    chk(rv, 32'h81, "resync");
    $display("slave done");
  endtask : t_slave
  task automatic t_off;
    apb(1, OFF_CONTROL, 8'h10);
    apb(1, OFF_PIN_DIR, 8'h0d);
    apb(1, OFF_DATA, 8'h42);
    repeat (40) @(posedge pclk);
    apb(0, OFF_STATUS, 8'h00);
    chk(rv, 32'h0, "no xfer");
    chk(sck_oe_n, 1, "no sck");
    $display("disabled done");
  endtask : t_off
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_master;
    t_collide;
    t_fault;
    t_slave;
    t_off;
    conclude;
  end
endmodule : spms_port_tb
`default_nettype wire
